// ---- logic/pwc_pkg.sv ----
// Package for the chip power mode controller: states, targets, exit codes,
// the control bundle and timing constants. Assumes a single 125 MHz clock.
package pwc_pkg;

   // Clock rate and wakeup-reset pulse length
   localparam int unsigned PWC_CLK_MHZ = 125;
   localparam int unsigned PWC_WRST_TIME_NS = 1000;
   localparam int unsigned PWC_WRST_CYCLES = (PWC_WRST_TIME_NS * PWC_CLK_MHZ + 999) / 1000;
   localparam int unsigned PWC_WAKE_W_DEF = 8;

   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [3:0] {
      ST_RUN           = 4'h0,
      ST_WAIT          = 4'h1,
      ST_STOP          = 4'h2,
      ST_LP_RUN        = 4'h3,
      ST_LP_WAIT       = 4'h4,
      ST_LP_STOP       = 4'h5,
      ST_LEAK_STOP     = 4'h6,
      ST_DEEP_RAM_KEPT = 4'h7,
      ST_DEEP_RAM_OFF  = 4'h8,
      ST_DEEPEST       = 4'h9,
      ST_WAKE_RESET    = 4'ha
   } pwc_state_t;

   // Mode chosen by software for the next wait-for-interrupt
   typedef enum logic [2:0] {
      TGT_WAIT      = 3'h0,
      TGT_STOP      = 3'h1,
      TGT_LEAK      = 3'h2,
      TGT_RAM_KEPT  = 3'h3,
      TGT_RAM_OFF   = 3'h4,
      TGT_DEEPEST   = 3'h5
   } pwc_target_t;

   // Last low-power mode left
   typedef enum logic [2:0] {
      EX_NONE     = 3'h0,
      EX_WAIT     = 3'h1,
      EX_STOP     = 3'h2,
      EX_LEAK     = 3'h3,
      EX_RAM_KEPT = 3'h4,
      EX_RAM_OFF  = 3'h5,
      EX_DEEPEST  = 3'h6
   } pwc_exit_t;

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic core_sleep;
      logic core_deep_sleep;
      logic periph_clk_en;
      logic reg_low_power;
      logic lvd_en;
      logic flash_slow;
      logic irc_fast_sel;
      logic nested_irq_controller_en;
      logic async_wakeup_controller_en;
      logic leakage_wakeup_unit_en;
      logic ram_pwr_en;
      logic lpo_en;
      logic bor_en;
      logic io_hold;
      logic tpm_uart_clk_en;
   } pwc_ctrl_t;

   localparam pwc_state_t PWC_STATE_RST = ST_RUN;
   localparam pwc_exit_t PWC_EXIT_RST = EX_NONE;

endpackage

// ---- logic/pwc_power_mode_controller.sv ----
// Chip power mode controller: run/wait/stop sequencing, wakeup and the
// wakeup reset flow. Assumes core, interrupt controller and clock gating
// logic on clk_sys; wakeup pins arrive asynchronously.
`timescale 1ns/1ns
`default_nettype none

module pwc_power_mode_controller #(
   parameter int unsigned WAKE_W = pwc_pkg::PWC_WAKE_W_DEF
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Core side
   input wire logic wfi_exec,
   input wire pwc_pkg::pwc_target_t stop_target,
   input wire logic lp_run_req,
   input wire logic irq_pend,
   input wire logic leakage_wakeup_unit_flag_clr,
   // Options
   input wire logic tpm_src_en,
   input wire logic bor_opt_en,
   // Wakeup sources
   input wire logic [WAKE_W-1:0] wake_pin,
   input wire logic [WAKE_W-1:0] wake_en,
   // Status and controls
   output pwc_pkg::pwc_state_t state_r,
   output pwc_pkg::pwc_ctrl_t ctrl_r,
   output logic wake_reset_n_r,
   output logic leakage_wakeup_unit_flag_r,
   output pwc_pkg::pwc_exit_t last_exit_r
);
   import pwc_pkg::*;

   initial begin
      if (WAKE_W < 1 || WAKE_W > 32) begin
         $error("WAKE_W must be 1 to 32");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Controls as a function of mode
   function automatic pwc_ctrl_t ctrl_of(input pwc_state_t st, input logic tpm_src, input logic bor_opt);
      pwc_ctrl_t c;
      c = '{core_sleep: 1'b0, core_deep_sleep: 1'b0, periph_clk_en: 1'b1, reg_low_power: 1'b0,
            lvd_en: 1'b1, flash_slow: 1'b0, irc_fast_sel: 1'b0, nested_irq_controller_en: 1'b1, async_wakeup_controller_en: 1'b0,
            leakage_wakeup_unit_en: 1'b0, ram_pwr_en: 1'b1, lpo_en: 1'b1, bor_en: 1'b1, io_hold: 1'b1,
            tpm_uart_clk_en: 1'b1};
      unique case (st)
         ST_RUN: begin
         end
         ST_WAIT: begin
            c.core_sleep = 1'b1;
         end
         ST_STOP: begin
            c.core_sleep = 1'b1;
            c.core_deep_sleep = 1'b1;
            c.periph_clk_en = 1'b0;
            c.nested_irq_controller_en = 1'b0;
            c.async_wakeup_controller_en = 1'b1;
            c.tpm_uart_clk_en = 1'b0;
         end
         ST_LP_RUN, ST_LP_WAIT: begin
            c.reg_low_power = 1'b1;
            c.lvd_en = 1'b0;
            c.flash_slow = 1'b1;
            c.irc_fast_sel = 1'b1;
            c.core_sleep = (st == ST_LP_WAIT);
         end
         ST_LP_STOP: begin
            c.core_sleep = 1'b1;
            c.core_deep_sleep = 1'b1;
            c.periph_clk_en = 1'b0;
            c.reg_low_power = 1'b1;
            c.lvd_en = 1'b0;
            c.flash_slow = 1'b1;
            c.nested_irq_controller_en = 1'b0;
            c.async_wakeup_controller_en = 1'b1;
            c.tpm_uart_clk_en = tpm_src;
         end
         ST_LEAK_STOP, ST_DEEP_RAM_KEPT, ST_DEEP_RAM_OFF, ST_DEEPEST: begin
            c.core_sleep = 1'b1;
            c.core_deep_sleep = 1'b1;
            c.periph_clk_en = 1'b0;
            c.reg_low_power = 1'b1;
            c.lvd_en = 1'b0;
            c.nested_irq_controller_en = 1'b0;
            c.leakage_wakeup_unit_en = 1'b1;
            c.tpm_uart_clk_en = 1'b0;
            c.ram_pwr_en = (st == ST_LEAK_STOP) || (st == ST_DEEP_RAM_KEPT);
            c.lpo_en = (st != ST_DEEPEST);
            c.bor_en = (st != ST_DEEPEST) || bor_opt;
         end
         ST_WAKE_RESET: begin
            c.periph_clk_en = 1'b0;
            c.nested_irq_controller_en = 1'b0;
            c.tpm_uart_clk_en = 1'b0;
         end
         default: begin
         end
      endcase
      c.io_hold = 1'b1;
      return c;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Wakeup pin synchroniser
   logic [WAKE_W-1:0] wake_s1_r;
   logic [WAKE_W-1:0] wake_s2_r;
   logic wake_hit;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wake_s1_r <= '0;
         wake_s2_r <= '0;
      end else begin
         wake_s1_r <= wake_pin;
         wake_s2_r <= wake_s1_r;
      end
   end

   assign wake_hit = |(wake_s2_r & wake_en);

   ////////////////////////////////////////////////////////////////////////////
   // Mode sequencing
   pwc_state_t state_nxt;
   logic [7:0] wrst_cnt_r;
   logic wrst_done;
   logic deep_state;

   assign wrst_done = (wrst_cnt_r == 8'h00);
   assign deep_state = (state_r == ST_DEEP_RAM_KEPT) || (state_r == ST_DEEP_RAM_OFF) ||
                       (state_r == ST_DEEPEST);

   function automatic pwc_state_t enter_of(input pwc_target_t t, input logic lp);
      pwc_state_t s;
      unique case (t)
         TGT_WAIT: s = lp ? ST_LP_WAIT : ST_WAIT;
         TGT_STOP: s = lp ? ST_LP_STOP : ST_STOP;
         TGT_LEAK: s = ST_LEAK_STOP;
         TGT_RAM_KEPT: s = ST_DEEP_RAM_KEPT;
         TGT_RAM_OFF: s = ST_DEEP_RAM_OFF;
         TGT_DEEPEST: s = ST_DEEPEST;
         // Undefined targets fall back to the lightest sleep
         default: s = lp ? ST_LP_WAIT : ST_WAIT;
      endcase
      return s;
   endfunction

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_RUN: begin
            if (wfi_exec) begin
               state_nxt = enter_of(stop_target, 1'b0);
            end else if (lp_run_req) begin
               state_nxt = ST_LP_RUN;
            end
         end
         ST_LP_RUN: begin
            if (wfi_exec) begin
               state_nxt = enter_of(stop_target, 1'b1);
            end else if (!lp_run_req) begin
               state_nxt = ST_RUN;
            end
         end
         ST_WAIT: begin
            if (irq_pend) begin
               state_nxt = ST_RUN;
            end
         end
         ST_LP_WAIT: begin
            if (irq_pend) begin
               state_nxt = ST_LP_RUN;
            end
         end
         ST_STOP: begin
            if (irq_pend || wake_hit) begin
               state_nxt = ST_RUN;
            end
         end
         ST_LP_STOP: begin
            if (irq_pend || wake_hit) begin
               state_nxt = ST_LP_RUN;
            end
         end
         ST_LEAK_STOP: begin
            if (wake_hit) begin
               state_nxt = ST_RUN;
            end
         end
         ST_DEEP_RAM_KEPT, ST_DEEP_RAM_OFF, ST_DEEPEST: begin
            if (wake_hit) begin
               state_nxt = ST_WAKE_RESET;
            end
         end
         ST_WAKE_RESET: begin
            if (wrst_done) begin
               state_nxt = ST_RUN;
            end
         end
         default: state_nxt = ST_RUN;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_r <= PWC_STATE_RST;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctrl_r <= ctrl_of(PWC_STATE_RST, 1'b0, 1'b0);
      end else begin
         ctrl_r <= ctrl_of(state_nxt, tpm_src_en, bor_opt_en);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wakeup reset pulse; the controller itself survives it so the record stays
   // reset pulse timing
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wrst_cnt_r <= 8'h00;
         wake_reset_n_r <= 1'b1;
      end else begin
         if (deep_state && wake_hit) begin
            wrst_cnt_r <= 8'(PWC_WRST_CYCLES - 1);
         end else if (!wrst_done) begin
            wrst_cnt_r <= wrst_cnt_r - 8'h01;
         end
         wake_reset_n_r <= (state_nxt != ST_WAKE_RESET);
      end
   end

   // flag left set; set beats clear
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         leakage_wakeup_unit_flag_r <= 1'b0;
      end else if ((state_r == ST_LEAK_STOP || deep_state) && wake_hit) begin
         leakage_wakeup_unit_flag_r <= 1'b1;
      end else if (leakage_wakeup_unit_flag_clr) begin
         leakage_wakeup_unit_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         last_exit_r <= PWC_EXIT_RST;
      end else if (state_nxt != state_r) begin
         unique case (state_r)
            ST_WAIT, ST_LP_WAIT: last_exit_r <= EX_WAIT;
            ST_STOP, ST_LP_STOP: last_exit_r <= EX_STOP;
            ST_LEAK_STOP: last_exit_r <= EX_LEAK;
            ST_DEEP_RAM_KEPT: last_exit_r <= EX_RAM_KEPT;
            ST_DEEP_RAM_OFF: last_exit_r <= EX_RAM_OFF;
            ST_DEEPEST: last_exit_r <= EX_DEEPEST;
            default: last_exit_r <= last_exit_r;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence seq_deep_wake;
      deep_state && wake_hit;
   endsequence

   sequence seq_reset_pulse;
      (state_r == ST_WAKE_RESET && !wake_reset_n_r) [*8];
   endsequence

   AST_RUN_FULL_POWER: assert property (
      state_r == ST_RUN |-> !ctrl_r.reg_low_power && ctrl_r.lvd_en && ctrl_r.periph_clk_en)
      else $error("normal run without full power");
   AST_WFI_ENTRY: assert property (
      state_r == ST_RUN && wfi_exec && stop_target == TGT_STOP |=> state_r == ST_STOP && !ctrl_r.periph_clk_en)
      else $error("stop not entered on instruction");
   AST_LP_FAMILY: assert property (
      state_r == ST_LP_RUN && wfi_exec && stop_target == TGT_WAIT |=> state_r == ST_LP_WAIT ##0 ctrl_r.reg_low_power)
      else $error("low power run did not enter its wait");
   AST_WAIT_IRQ: assert property (
      state_r == ST_WAIT && irq_pend |=> state_r == ST_RUN && !ctrl_r.core_sleep)
      else $error("wait not left on interrupt");
   AST_STOP_CTRL: assert property (
      state_r == ST_STOP |-> !ctrl_r.periph_clk_en && ctrl_r.lvd_en && !ctrl_r.nested_irq_controller_en && ctrl_r.async_wakeup_controller_en)
      else $error("normal stop controls wrong");
   AST_LP_RUN_CTRL: assert property (
      state_r == ST_LP_RUN |-> ctrl_r.reg_low_power && !ctrl_r.lvd_en && ctrl_r.flash_slow)
      else $error("low power run controls wrong");
   AST_LP_STOP_TIMER: assert property (
      state_r == ST_LP_STOP && $stable(state_r) |-> ctrl_r.tpm_uart_clk_en == $past(tpm_src_en) && !ctrl_r.lvd_en)
      else $error("low power stop timer gating wrong");
   AST_LEAK_RESUME: assert property (
      state_r == ST_LEAK_STOP && wake_hit |=> state_r == ST_RUN && leakage_wakeup_unit_flag_r)
      else $error("leakage stop did not resume run");
   AST_DEEP_RESET: assert property (
      seq_deep_wake |=> seq_reset_pulse ##[1:200] (state_r == ST_RUN && wake_reset_n_r && leakage_wakeup_unit_flag_r))
      else $error("deep wake reset flow wrong");
   AST_RAM_POWER: assert property (
      (state_r == ST_DEEP_RAM_KEPT |-> ctrl_r.ram_pwr_en) and
      (state_r == ST_DEEP_RAM_OFF || state_r == ST_DEEPEST |-> !ctrl_r.ram_pwr_en))
      else $error("RAM power wrong in deep stop");
   AST_DEEPEST_OSC: assert property (
      state_r == ST_DEEPEST |-> !ctrl_r.lpo_en && ctrl_r.bor_en == $past(bor_opt_en))
      else $error("deepest stop oscillator wrong");
   AST_IO_HOLD: assert property (
      ctrl_r.io_hold)
      else $error("pin hold dropped");
   AST_LAST_EXIT: assert property (
      state_r == ST_DEEP_RAM_OFF && wake_hit |=> last_exit_r == EX_RAM_OFF)
      else $error("exit record wrong");

endmodule

`default_nettype wire

// ---- verification/pwc_far_model.sv ----
// Far-side model: interrupt controller, wake sources and wakeup service.
// Assumes the bench drives its requests on clk_sys rising edges.
`timescale 1ns/1ns
`default_nettype none

module pwc_far_model #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Bench requests
   input wire logic irq_req,
   input wire logic [W-1:0] wake_req,
   input wire logic svc_en,
   input wire logic slow,
   // Controller side
   input wire logic leakage_wakeup_unit_flag_r,
   input wire logic wake_reset_n_r,
   output logic irq_pend,
   output logic [W-1:0] wake_pin,
   output logic leakage_wakeup_unit_flag_clr
);
   logic [2:0] dly_r;

   ////////////////////////////////////////////////////////////
   // Slow mode holds a request back, like a busy controller
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         dly_r <= 3'h0;
         irq_pend <= 1'b0;
      end else begin
         dly_r <= irq_req ? dly_r + 3'h1 : 3'h0;
         irq_pend <= irq_req && (!slow || dly_r == 3'h7 || irq_pend);
      end
   end

   // Pins move off the clock edge, as an asynchronous source would
   always_ff @(negedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wake_pin <= '0;
      end else begin
         wake_pin <= wake_req;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         leakage_wakeup_unit_flag_clr <= 1'b0;
      end else begin
         leakage_wakeup_unit_flag_clr <= svc_en && leakage_wakeup_unit_flag_r && wake_reset_n_r && !leakage_wakeup_unit_flag_clr;
      end
   end
endmodule

`default_nettype wire

// ---- verification/tb.sv ----
// Bench for the power mode controller: random mode entry and exit,
// compared every cycle with a behavioural model. Assumes pwc_far_model.
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
   $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module tb;
   import pwc_pkg::*;
   localparam int W = 4;
   logic clk_sys, resetn, wfi_exec, lp_run_req, irq_pend, leakage_wakeup_unit_flag_clr;
   logic tpm_src_en, bor_opt_en, irq_req, svc_en, slow, hit;
   logic [W-1:0] wake_pin, wake_en, wake_req, s1, s2;
   pwc_target_t stop_target;
   pwc_state_t state_r, m_st;
   pwc_ctrl_t ctrl_r;
   logic wake_reset_n_r, leakage_wakeup_unit_flag_r, m_flag;
   pwc_exit_t last_exit_r, m_ex;
   logic [29:0] em;
   int n_fail, comparisons, m_cnt;

   pwc_power_mode_controller #(.WAKE_W(W)) u_dut (.clk_sys(clk_sys), .resetn(resetn),
      .wfi_exec(wfi_exec), .stop_target(stop_target), .lp_run_req(lp_run_req), .irq_pend(irq_pend),
      .leakage_wakeup_unit_flag_clr(leakage_wakeup_unit_flag_clr), .tpm_src_en(tpm_src_en), .bor_opt_en(bor_opt_en),
      .wake_pin(wake_pin), .wake_en(wake_en), .state_r(state_r), .ctrl_r(ctrl_r),
      .wake_reset_n_r(wake_reset_n_r), .leakage_wakeup_unit_flag_r(leakage_wakeup_unit_flag_r), .last_exit_r(last_exit_r));
   pwc_far_model #(.W(W)) u_far (.clk_sys(clk_sys), .resetn(resetn), .irq_req(irq_req),
      .wake_req(wake_req), .svc_en(svc_en), .slow(slow), .leakage_wakeup_unit_flag_r(leakage_wakeup_unit_flag_r),
      .wake_reset_n_r(wake_reset_n_r), .irq_pend(irq_pend), .wake_pin(wake_pin),
      .leakage_wakeup_unit_flag_clr(leakage_wakeup_unit_flag_clr));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////
   function automatic pwc_state_t enter(logic [2:0] t, logic lp);
      case (t)
         3'h1: return lp ? ST_LP_STOP : ST_STOP;
         3'h2: return ST_LEAK_STOP;
         3'h3: return ST_DEEP_RAM_KEPT;
         3'h4: return ST_DEEP_RAM_OFF;
         3'h5: return ST_DEEPEST;
         default: return lp ? ST_LP_WAIT : ST_WAIT;
      endcase
   endfunction

   // Expected controls and the mask of bits the modes really fix
   function automatic logic [29:0] ctl(pwc_state_t s);
      case (s)
         ST_RUN: return {15'h1492, 15'h7cf2};
         ST_WAIT: return {15'h5492, 15'h7882};
         ST_STOP: return {15'h6452, 15'h74d2};
         ST_LP_RUN: return {15'h1a92, 15'h4e82};
         ST_LP_WAIT: return {15'h4a82, 15'h4c82};
         ST_LP_STOP: return {15'h2852 | {14'h0, tpm_src_en}, 15'h3cd3};
         ST_LEAK_STOP, ST_DEEP_RAM_KEPT: return {15'h2032, 15'h30b2};
         ST_DEEP_RAM_OFF: return {15'h2022, 15'h30b2};
         ST_DEEPEST: return {15'h2022 | {12'h0, bor_opt_en, 2'h0}, 15'h30be};
         default: return {15'h0002, 15'h0002};
      endcase
   endfunction

   task automatic go_deep(pwc_exit_t x);
      m_st = ST_WAKE_RESET;
      m_ex = x;
      m_flag = 1'b1;
      m_cnt = PWC_WRST_CYCLES;
   endtask

   // Reference model, stepped on the values seen before each edge
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         m_st = ST_RUN;
         m_ex = EX_NONE;
         m_flag = 1'b0;
         s1 = '0;
         s2 = '0;
      end else begin
         hit = |(s2 & wake_en);
         s2 = s1;
         s1 = wake_pin;
         if (leakage_wakeup_unit_flag_clr) m_flag = 1'b0;
         case (m_st)
            ST_RUN, ST_LP_RUN: begin
               if (wfi_exec) m_st = enter(stop_target, m_st == ST_LP_RUN);
               else m_st = lp_run_req ? ST_LP_RUN : ST_RUN;
            end
            ST_WAIT, ST_LP_WAIT: begin
               if (irq_pend) begin
                  m_st = (m_st == ST_WAIT) ? ST_RUN : ST_LP_RUN;
                  m_ex = EX_WAIT;
               end
            end
            ST_STOP, ST_LP_STOP: begin
               if (irq_pend || hit) begin
                  m_st = (m_st == ST_STOP) ? ST_RUN : ST_LP_RUN;
                  m_ex = EX_STOP;
               end
            end
            ST_LEAK_STOP: begin
               if (hit) begin
                  m_st = ST_RUN;
                  m_ex = EX_LEAK;
                  m_flag = 1'b1;
               end
            end
            ST_DEEP_RAM_KEPT: if (hit) go_deep(EX_RAM_KEPT);
            ST_DEEP_RAM_OFF: if (hit) go_deep(EX_RAM_OFF);
            ST_DEEPEST: if (hit) go_deep(EX_DEEPEST);
            default: begin
               if (m_cnt == 1) m_st = ST_RUN;
               m_cnt--;
            end
         endcase
      end
   end

   always @(negedge clk_sys) begin
      em = ctl(m_st);
      `CHK("state", m_st, state_r)
      `CHK("ctrl", em[29:15] & em[14:0], ctrl_r & em[14:0])
      `CHK("wake_reset_n", m_st != ST_WAKE_RESET, wake_reset_n_r)
      `CHK("flag", m_flag, leakage_wakeup_unit_flag_r)
      `CHK("last_exit", m_ex, last_exit_r)
   end

   ////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic tick(int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic wait_st(pwc_state_t s);
      int i;
      i = 0;
      while (state_r !== s && i < 400) begin
         @(negedge clk_sys);
         i++;
      end
      if (i == 400) begin
         n_fail++;
         $display("wrong value wait_state expected %0h seen %0h", s, state_r);
         finish_test();
      end
   endtask

   // One pulse; a second one while asleep must be ignored
   task automatic wait_for_interrupt_instr(logic [2:0] t);
      @(posedge clk_sys);
      stop_target <= pwc_target_t'(t);
      wfi_exec <= 1'b1;
      @(posedge clk_sys);
      wfi_exec <= 1'b0;
   endtask

   initial begin
      // A clean falling edge on reset, so the design and the model both reset on it
      resetn = 1'b1;
      {wfi_exec, lp_run_req, irq_req, svc_en, slow, tpm_src_en, bor_opt_en} = '0;
      #1 resetn = 1'b0;
      wake_en = '0;
      wake_req = '0;
      stop_target = TGT_WAIT;
      n_fail = 0;
      comparisons = 0;
      void'($urandom(94));
      tick(8);
      resetn <= 1'b1;
      for (int i = 0; i < 48; i++) begin
         tick(1);
         lp_run_req <= (i < 16) ? (i >= 8) : 1'($urandom);
         {tpm_src_en, bor_opt_en, svc_en, slow} <= 4'($urandom);
         wake_en <= W'($urandom_range(15, 1));
         tick(3);
         wait_for_interrupt_instr((i < 16) ? 3'(i) : 3'($urandom));
         tick($urandom_range(5, 1));
         wait_for_interrupt_instr(3'($urandom));
         irq_req <= 1'b1;
         tick(12);
         irq_req <= 1'b0;
         wake_req <= ~wake_en;
         tick(6);
         wake_req <= wake_en;
         tick(8);
         wake_req <= '0;
         lp_run_req <= 1'b0;
         wait_st(ST_RUN);
         $display("test %0d done", i);
      end
      wait_for_interrupt_instr(3'h3);
      tick(10);
      resetn <= 1'b0;
      tick(3);
      resetn <= 1'b1;
      tick(4);
      $display("test reset in stop done");
      finish_test();
   end
endmodule

`default_nettype wire
